// ### hdl/mrr_params.svh
// Purpose: Named constants for the motion report register group.
// Assumes: Byte-wide registers at byte addresses on the serial port.
// Notes: Included by the package and the modules.
`ifndef MRR_PARAMS_SVH
`define MRR_PARAMS_SVH
`define MRR_ADDR_REV 7'h01
`define MRR_ADDR_MST 7'h02
`define MRR_ADDR_DX 7'h03
`define MRR_ADDR_DY 7'h04
`define MRR_ADDR_SQ 7'h05
`define MRR_MOTION_BIT 7
`define MRR_REV_VALUE 8'h5A
`define MRR_SQ_MAX 9'h100
`define MRR_DELTA_MAX 8'h7F
`define MRR_DELTA_MIN 8'h80
`define MRR_ZERO8 8'h00
`endif

// ### hdl/mrr_pkg.sv
// Purpose: Types shared by the motion report register group.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the register select enumeration.
`include "mrr_params.svh"
package mrr_pkg;
   typedef enum logic [5:0] {
      MRR_SEL_NONE = 6'h01,
      MRR_SEL_REV = 6'h02,
      MRR_SEL_MST = 6'h04,
      MRR_SEL_DX = 6'h08,
      MRR_SEL_DY = 6'h10,
      MRR_SEL_SQ = 6'h20
   } mrr_sel_t;
endpackage : mrr_pkg

// ### hdl/mrr_sat_acc.sv
// Purpose: Saturating signed 8-bit displacement accumulator for one axis.
// Assumes: Same clock as the register group.
// Notes: Clear and add in one cycle keeps the new sample.
`include "mrr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mrr_sat_acc (
   input wire logic clk,            // System clock.
   input wire logic rst_b,          // Asynchronous reset, active low.
   input wire logic clr,            // Clear the total.
   input wire logic addEn,          // Add the sample this cycle.
   input wire logic [7:0] sample,   // Signed displacement sample.
   output logic [7:0] total         // Signed saturated total.
);
   logic [8:0] sumW;
   logic [7:0] base;
   // Sum with one guard bit to see overflow.
   always_comb begin
      base = clr ? `MRR_ZERO8 : total;
      sumW = {base[7], base} + {sample[7], sample};
   end
   // Clamp to the signed byte range.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         total <= `MRR_ZERO8;
      end else if (addEn) begin
         if (sumW[8] != sumW[7]) begin
            total <= sumW[8] ? `MRR_DELTA_MIN : `MRR_DELTA_MAX;
         end else begin
            total <= sumW[7:0];
         end
      end else if (clr) begin
         total <= `MRR_ZERO8;
      end
   end
endmodule : mrr_sat_acc
`default_nettype wire

// ### hdl/mrr_regs.sv
// Purpose: Motion report registers read by the serial port master.
// Assumes: Port logic delivers a decoded byte access on clk.
// Notes: Navigation core supplies per-frame samples on clk.
//
// Notes on behaviour
// - Motion pending flag is bit 7 of status, cleared at reset.
// - Flag sets when displacement occurs since the last report.
// - Flag holds motion from any frame since the last report.
// - Quality register holds upper eight bits of a nine-bit count.
// - Quality count measures valid features in the current frame.
// - Quality register never exceeds 128.
// - Quality reads near zero with no surface present.
`include "mrr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mrr_regs
   import mrr_pkg::*;
(
   input wire logic clk,               // System clock, 50 MHz.
   input wire logic rst_b,             // Asynchronous reset, active low.
   input wire logic regStb,            // One-cycle register access strobe.
   input wire logic regWr,             // High for write, low for read.
   input wire logic [6:0] regAddr,     // Register address.
   input wire logic [7:0] regWdata,    // Write data.
   input wire logic frameDone,         // One-cycle pulse per frame.
   input wire logic [7:0] frameDx,     // Signed X movement of the frame.
   input wire logic [7:0] frameDy,     // Signed Y movement of the frame.
   input wire logic [8:0] featureCnt,  // Valid features in the frame.
   output logic [7:0] regRdata,        // Read data, from a register.
   output logic regRvalid,             // One-cycle read data valid.
   output logic motionPending          // Motion pending flag level.
);
   logic motion_q;
   logic [8:0] quality_q;
   logic [7:0] dx;
   logic [7:0] dy;
   logic frameMoved;
   logic clrReport;
   mrr_sel_t sel;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic mrr_sel_t decode(input logic [6:0] a);
      case (a)
         `MRR_ADDR_REV: decode = MRR_SEL_REV;
         `MRR_ADDR_MST: decode = MRR_SEL_MST;
         `MRR_ADDR_DX: decode = MRR_SEL_DX;
         `MRR_ADDR_DY: decode = MRR_SEL_DY;
         `MRR_ADDR_SQ: decode = MRR_SEL_SQ;
         default: decode = MRR_SEL_NONE;
      endcase
   endfunction : decode

   // Select and report clearing by status write.
   always_comb begin
      sel = decode(regAddr);
      clrReport = regStb && regWr && (sel == MRR_SEL_MST);
      frameMoved = frameDone && ((frameDx != `MRR_ZERO8) ||
                                 (frameDy != `MRR_ZERO8));
   end

   // ------------------------------------------------------------
   // Displacement accumulators
   // ------------------------------------------------------------
   // Totals since last report; status write restarts them.
   mrr_sat_acc accX (
      .clk(clk),
      .rst_b(rst_b),
      .clr(clrReport),
      .addEn(frameDone),
      .sample(frameDx),
      .total(dx)
   );
   mrr_sat_acc accY (
      .clk(clk),
      .rst_b(rst_b),
      .clr(clrReport),
      .addEn(frameDone),
      .sample(frameDy),
      .total(dy)
   );

   // ------------------------------------------------------------
   // Motion pending flag
   // ------------------------------------------------------------
   // Sticky until cleared; a new motion in the clear cycle wins.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         motion_q <= 1'b0;
      end else if (frameMoved) begin
         motion_q <= 1'b1;
      end else if (clrReport) begin
         motion_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Surface quality
   // ------------------------------------------------------------
   // Feature count of the latest frame, limited to the top value.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         quality_q <= 9'h000;
      end else if (frameDone) begin
         if (featureCnt > `MRR_SQ_MAX) begin
            quality_q <= `MRR_SQ_MAX;
         end else begin
            quality_q <= featureCnt;
         end
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Registered read data; unmapped addresses read zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdata <= `MRR_ZERO8;
      end else if (regStb && !regWr) begin
         case (sel)
            MRR_SEL_REV: regRdata <= `MRR_REV_VALUE;
            MRR_SEL_MST: regRdata <= {motion_q, 7'h00};
            MRR_SEL_DX: regRdata <= dx;
            MRR_SEL_DY: regRdata <= dy;
            MRR_SEL_SQ: regRdata <= quality_q[8:1];
            default: regRdata <= `MRR_ZERO8;
         endcase
      end
   end

   // Read valid pulse and flag output.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regRvalid <= 1'b0;
         motionPending <= 1'b0;
      end else begin
         regRvalid <= regStb && !regWr;
         motionPending <= motion_q;
      end
   end
endmodule : mrr_regs
`default_nettype wire

// ### bench/mrr_regs_assertions.sv
// Purpose: Port checker.
// Assumes: mrr_regs ports.
// Notes: Bound below.
`timescale 1ns/1ps
`default_nettype none
module mrr_regs_chk (
   input wire logic clk, // Clock.
   input wire logic rst_b, // Reset.
   input wire logic regStb, // Strobe.
   input wire logic regWr, // Write.
   input wire logic [6:0] regAddr, // Address.
   input wire logic frameDone, // Frame.
   input wire logic [7:0] frameDx, // X step.
   input wire logic [7:0] regRdata, // Data.
   input wire logic regRvalid, // Valid.
   input wire logic motionPending // Flag.
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Read, status clear and frame with nonzero X step.
   wire logic rd = regStb && !regWr;
   wire logic clr = regStb && regWr && regAddr == 7'h02;
   wire logic mv = frameDone && frameDx != 8'h00;
   AST_RD_ON: assert property (rd |=> regRvalid)
      else $error("no answer");
   AST_RD_OFF: assert property (!rd |=> !regRvalid)
      else $error("stray valid");
   AST_HOLD: assert property (!rd |=> $stable(regRdata))
      else $error("data moved");
   AST_STATUS: assert property (rd && regAddr == 7'h02
      |=> regRdata == {motionPending, 7'h00}) else $error("bad status");
   AST_SET: assert property (mv |=> ##1 motionPending)
      else $error("no set");
   AST_KEEP: assert property (motionPending && !clr && !$past(clr)
      |=> motionPending) else $error("flag lost");
   AST_CLEAR: assert property (clr && !frameDone
      |=> ##1 !motionPending) else $error("flag kept");
   AST_SQ_MAX: assert property (rd && regAddr == 7'h05
      |=> regRdata <= 8'h80) else $error("quality high");
endmodule : mrr_regs_chk
bind mrr_regs mrr_regs_chk chk_u (.*);
`default_nettype wire

// ### bench/mrr_host.sv
// Purpose: Port master model.
// Assumes: Drives 1 ns after the edge.
// Notes: Idle address is inverted.
`timescale 1ns/1ps
`default_nettype none
module mrr_host (
   input wire logic clk, // Clock.
   output logic regStb, // Strobe.
   output logic regWr, // Write.
   output logic [6:0] regAddr, // Address.
   output logic [7:0] regWdata, // Data out.
   input wire logic [7:0] regRdata // Data in.
);
   // Idle bus from time zero.
   initial begin
      regStb = 1'h0;
      regWr = 1'h0;
      regAddr = 7'h00;
      regWdata = 8'h00;
   end
   // Two back-to-back accesses, a then b.
   task acc(input logic w, input logic [6:0] a, input logic [6:0] b,
      output logic [7:0] d, output logic [7:0] e);
      @(posedge clk) #1;
      regStb = 1'h1;
      regWr = w;
      regAddr = a;
      @(posedge clk) #1;
      regAddr = b;
      d = regRdata;
      @(posedge clk) #1;
      regStb = 1'h0;
      regAddr = ~b;
      e = regRdata;
   endtask : acc
endmodule : mrr_host
`default_nettype wire

// ### bench/motion_report_registers_tb.sv
// Purpose: Bench for the motion report registers.
// Assumes: Host model drives the port.
// Notes: Frames come from the bench.
`include "mrr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module motion_report_registers_tb;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic frameDone = 1'h0;
   logic regStb, regWr, regRvalid, motionPending;
   logic [6:0] regAddr;
   logic [7:0] regWdata, regRdata, d, e;
   logic [7:0] frameDx = 8'h00;
   logic [7:0] frameDy = 8'h00;
   logic [8:0] featureCnt = 9'h000;
   int n_mismatch = 0;
   int checks = 0;
   // Clock of 20 ns.
   always #10 clk = ~clk;
   mrr_host host_u (
      .clk(clk),
      .regStb(regStb),
      .regWr(regWr),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regRdata(regRdata)
   );
   mrr_regs dut_u (
      .clk(clk),
      .rst_b(rst_b),
      .regStb(regStb),
      .regWr(regWr),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .frameDone(frameDone),
      .frameDx(frameDx),
      .frameDy(frameDy),
      .featureCnt(featureCnt),
      .regRdata(regRdata),
      .regRvalid(regRvalid),
      .motionPending(motionPending)
   );
   task chk(input string n, input logic [7:0] x, input logic [7:0] s);
      checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task frame(input logic [7:0] x, input logic [7:0] y, input logic [8:0] c);
      @(posedge clk) #1;
      frameDone = 1'h1;
      frameDx = x;
      frameDy = y;
      featureCnt = c;
      @(posedge clk) #1;
      frameDone = 1'h0;
   endtask : frame
   task t_reset;
      logic [7:0] x [6] = '{`MRR_REV_VALUE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) begin
         host_u.acc(1'h0, 7'(i + 1), 7'(i + 1), d, e);
         chk("reg", x[i], d);
      end
      $display("t_reset end");
   endtask : t_reset
   task t_motion;
      frame(8'h05, 8'hFD, 9'h000);
      frame(8'h00, 8'h00, 9'h000);
      chk("pend1", 8'h01, {7'h00, motionPending});
      host_u.acc(1'h0, 7'h02, 7'h02, d, e);
      chk("status1", 8'h80, d);
      host_u.acc(1'h0, 7'h03, 7'h04, d, e);
      chk("dx", 8'h05, d);
      chk("dy", 8'hFD, e);
      host_u.acc(1'h1, 7'h02, 7'h02, d, e);
      frame(8'h00, 8'h00, 9'h000);
      chk("pend0", 8'h00, {7'h00, motionPending});
      host_u.acc(1'h0, 7'h02, 7'h04, d, e);
      chk("status", 8'h00, d);
      chk("dy0", 8'h00, e);
      $display("t_motion end");
   endtask : t_motion
   task t_sat;
      repeat (3) frame(8'h70, 8'h90, 9'h000);
      host_u.acc(1'h0, 7'h03, 7'h04, d, e);
      chk("dxsat", 8'h7F, d);
      chk("dysat", 8'h80, e);
      host_u.acc(1'h1, 7'h02, 7'h02, d, e);
      $display("t_sat end");
   endtask : t_sat
   task t_squal;
      logic [8:0] c [5] = '{9'h000, 9'h003, 9'h0FF, 9'h100, 9'h1FF};
      logic [8:0] m;
      foreach (c[i]) begin
         frame(8'h00, 8'h00, c[i]);
         m = (c[i] > 9'h100) ? 9'h100 : c[i];
         host_u.acc(1'h0, 7'h05, 7'h05, d, e);
         chk("squal", m[8:1], d);
      end
      $display("t_squal end");
   endtask : t_squal
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // Reset for five cycles, then the tests.
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_b = 1'h1;
      t_reset;
      t_motion;
      t_sat;
      t_squal;
      tally_and_finish;
   end
   // Watchdog well past the expected run.
   initial begin
      #20000;
      n_mismatch++;
      tally_and_finish;
   end
endmodule : motion_report_registers_tb
`default_nettype wire
